// File: src/hsi_pkg.sv
/*
  Shared constants of the humidity sensor serial slave and its measurement
  sequencer: timing figures, derived cycle counts, bus address and opcodes.
  Assumes a 200 MHz system clock and a 30 ns link sampling clock.
*/
package hsi_pkg;

  // clock rates
  localparam int unsigned MCLK_MHZ = 200;
  localparam int unsigned LINK_PERIOD_NS = 30;

  // measurement timing in microseconds, period in milliseconds
  localparam int unsigned T_STARTUP_US = 10000;
  localparam int unsigned T_CAP_US = 7840;
  localparam int unsigned T_RES_US = 960;
  localparam int unsigned T_CALC_US = 800;
  localparam int unsigned T_CYCLE_MS = 200;
  // least data hold the slave gives after the clock falls
  localparam int unsigned T_HOLD_NS = 300;

  // derived cycle counts (whole numbers at 200 MHz; hold rounded up in link periods)
  localparam int unsigned CNT_STARTUP = T_STARTUP_US * MCLK_MHZ;
  localparam int unsigned CNT_CAP = T_CAP_US * MCLK_MHZ;
  localparam int unsigned CNT_RES = T_RES_US * MCLK_MHZ;
  localparam int unsigned CNT_CALC = T_CALC_US * MCLK_MHZ;
  localparam int unsigned CNT_CYCLE = T_CYCLE_MS * 1000 * MCLK_MHZ;
  localparam int unsigned CNT_HOLD = (T_HOLD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

  // bus address, opcode and result addresses
  localparam logic [6:0] SLAVE_ADDR = 7'h28;
  localparam logic [7:0] CMD_RD_RESULT = 8'h40;
  localparam logic [6:0] RES_TEMP = 7'h00;
  localparam logic [6:0] RES_HUM = 7'h03;

  // reset values
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [6:0] PTR_RST = 7'h00;

endpackage : hsi_pkg

// File: src/hsi_meas_seq.sv
/*
  Measurement sequencer: start-up wait, capacitance conversion, resistance
  conversion and calculation, repeated by a period timer. Runs on mclk_i.
  Assumes the analog front end presents compensated results on temp_i/hum_i.
*/
`timescale 1ns/1ps
module hsi_meas_seq
  import hsi_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = CNT_STARTUP,
  parameter int unsigned CAP_CYC = CNT_CAP,
  parameter int unsigned RES_CYC = CNT_RES,
  parameter int unsigned CALC_CYC = CNT_CALC,
  parameter int unsigned CYCLE_CYC = CNT_CYCLE
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [15:0] temp_i,
  input wire logic [15:0] hum_i,
  output logic [15:0] temp_o,
  output logic [15:0] hum_o,
  output logic upd_tgl_o,
  output logic cap_busy_o,
  output logic res_busy_o,
  output logic calc_busy_o
);

  typedef enum logic [2:0] {S_STARTUP, S_CAP, S_RES, S_CALC, S_WAIT} hsi_seq_state_t;

  hsi_seq_state_t state_q, state_d;
  logic [31:0] tmr_q, tmr_d, per_q, per_d;
  logic [15:0] temp_d, hum_d;
  logic tgl_d;
  logic cap_go;

  // next state: phase timer per step, period timer from each capacitance start
  always_comb begin
    state_d = state_q;
    tmr_d = (tmr_q != 32'h0) ? tmr_q - 32'h1 : tmr_q;
    per_d = (per_q != 32'h0) ? per_q - 32'h1 : per_q;
    temp_d = temp_o;
    hum_d = hum_o;
    tgl_d = upd_tgl_o;
    case (state_q)
      S_STARTUP: if (tmr_q == 32'h0) state_d = S_CAP;
      S_CAP: if (tmr_q == 32'h0) begin
        state_d = S_RES;
        tmr_d = 32'(RES_CYC - 1);
      end
      S_RES: if (tmr_q == 32'h0) begin
        state_d = S_CALC;
        tmr_d = 32'(CALC_CYC - 1);
      end
      S_CALC: if (tmr_q == 32'h0) begin
        state_d = S_WAIT;
        temp_d = temp_i;
        hum_d = hum_i;
        tgl_d = ~upd_tgl_o;
      end
      S_WAIT: if (per_q == 32'h0) state_d = S_CAP;
      default: state_d = S_STARTUP;
    endcase
    cap_go = (state_q != S_CAP) && (state_d == S_CAP);
    if (cap_go) begin
      tmr_d = 32'(CAP_CYC - 1);
      per_d = 32'(CYCLE_CYC - 1);
    end
  end

  // registers; start-up wait is armed by reset itself
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= S_STARTUP;
      tmr_q <= 32'(STARTUP_CYC - 1);
      per_q <= 32'h0;
      temp_o <= RESULT_RST;
      hum_o <= RESULT_RST;
      upd_tgl_o <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      per_q <= per_d;
      temp_o <= temp_d;
      hum_o <= hum_d;
      upd_tgl_o <= tgl_d;
    end
  end

  assign cap_busy_o = (state_q == S_CAP);
  assign res_busy_o = (state_q == S_RES);
  assign calc_busy_o = (state_q == S_CALC);

  // the three steps must fit inside one period, leaving a wait
  if (CAP_CYC < 1 || RES_CYC < 1 || CALC_CYC < 1 || STARTUP_CYC < 1 ||
      CAP_CYC + RES_CYC + CALC_CYC >= CYCLE_CYC) begin : g_bad_timing
    $error("hsi_meas_seq: step counts do not fit the period");
  end

  // helper counters read only by the checks below
  logic [31:0] dur_q, gap_q;
  logic started_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dur_q <= 32'h0;
      gap_q <= 32'h0;
      started_q <= 1'b0;
    end else begin
      dur_q <= (state_d != state_q) ? 32'h0 : dur_q + 32'h1;
      gap_q <= cap_go ? 32'h1 : gap_q + 32'h1;
      started_q <= started_q | cap_go;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_startup_wait: assert property (cap_go && !started_q |-> gap_q == STARTUP_CYC - 1)
    else $error("first conversion not after start-up wait");
  a_cap_then_res: assert property ((state_q == S_CAP && state_d != S_CAP) |-> state_d == S_RES)
    else $error("capacitance step not followed by resistance step");
  a_cap_length: assert property ((state_q == S_CAP && state_d != S_CAP) |-> dur_q == CAP_CYC - 1)
    else $error("capacitance step has wrong length");
  a_res_length: assert property ((state_q == S_RES) ##1 (state_q == S_CALC) |-> $past(dur_q) == RES_CYC - 1)
    else $error("resistance step has wrong length");
  a_calc_length: assert property ((state_q == S_CALC && state_d != S_CALC) |-> dur_q == CALC_CYC - 1)
    else $error("calculation step has wrong length");
  a_result_update: assert property ((state_q == S_CALC && state_d == S_WAIT) |=>
    (temp_o == $past(temp_i) && hum_o == $past(hum_i) && upd_tgl_o != $past(upd_tgl_o)))
    else $error("results not written after calculation");
  a_cycle_period: assert property (cap_go && started_q |-> gap_q == CYCLE_CYC)
    else $error("measurement period wrong");
  c_second_cycle: cover property (cap_go && started_q);

endmodule : hsi_meas_seq

// File: src/hsi_i2c_slave.sv
/*
  Top of the humidity sensor: serial bus slave on a link sampling clock,
  plus the measurement sequencer on mclk_i, results crossing by toggle.
  Assumes an external master drives scl and pull-ups resolve sda from
  sda_oe_o; link_clk_i runs free and is unrelated to mclk_i.
*/
// How it works
// - after reset wait 10 ms, then measure
// - capacitance first, resistance after it completes
// - steps last 7.84 ms, 960 us, 800 us
// - calculation writes temperature and humidity results
// - cycle restarts every 200 ms
// - slave only, never drives the clock
// - data bits taken on clock rising edge
// - answers only address 0x28
// - each byte acknowledged low by receiver
// - on writes slave drives only acknowledge
// - master not-acknowledge ends read, bus released
// - master acknowledge increments address, next byte
// - opcode 0x40 then address 0x00 or 0x03
// - results high, low, then checksum byte
`timescale 1ns/1ps
module hsi_i2c_slave
  import hsi_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = CNT_STARTUP,
  parameter int unsigned CAP_CYC = CNT_CAP,
  parameter int unsigned RES_CYC = CNT_RES,
  parameter int unsigned CALC_CYC = CNT_CALC,
  parameter int unsigned CYCLE_CYC = CNT_CYCLE,
  parameter int unsigned HOLD_CYC = CNT_HOLD
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [15:0] temp_i,
  input wire logic [15:0] hum_i,
  output logic cap_busy_o,
  output logic res_busy_o,
  output logic calc_busy_o
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } hsi_bus_state_t;

  if (HOLD_CYC < 1 || HOLD_CYC > 255) begin : g_bad_hold
    $error("hsi_i2c_slave: HOLD_CYC out of range");
  end

  // measurement side, mclk domain
  logic [15:0] temp_w, hum_w;
  logic upd_tgl_w;

  hsi_meas_seq #(
    .STARTUP_CYC(STARTUP_CYC),
    .CAP_CYC(CAP_CYC),
    .RES_CYC(RES_CYC),
    .CALC_CYC(CALC_CYC),
    .CYCLE_CYC(CYCLE_CYC)
  ) u_seq (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .temp_i(temp_i),
    .hum_i(hum_i),
    .temp_o(temp_w),
    .hum_o(hum_w),
    .upd_tgl_o(upd_tgl_w),
    .cap_busy_o(cap_busy_o),
    .res_busy_o(res_busy_o),
    .calc_busy_o(calc_busy_o)
  );

  // link reset: asserted at once, released on the link clock
  logic [1:0] lrst_q;
  logic lrst;
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lrst_q <= 2'h3;
    end else begin
      lrst_q <= {lrst_q[0], 1'b0};
    end
  end
  assign lrst = lrst_q[1];

  // link domain state
  hsi_bus_state_t state_q, state_d;
  logic [2:0] scl_sy_q, scl_sy_d, sda_sy_q, sda_sy_d, tgl_sy_q, tgl_sy_d;
  logic scl_q, scl_d, sda_q, sda_d;
  logic seen_q, seen_d;
  logic [15:0] rtemp_q, rtemp_d, rhum_q, rhum_d;
  logic [2:0] bit_q, bit_d;
  logic [1:0] ph_q, ph_d;
  logic [1:0] wr_idx_q, wr_idx_d;
  logic rw_q, rw_d, cmd_q, cmd_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d;
  logic [6:0] ptr_q, ptr_d;
  logic [7:0] hold_q, hold_d;
  logic oe_d, want;
  logic scl_rise, scl_fall, start, stop;
  logic [7:0] rx_byte;
  logic addr_done, addr_hit, wr_done, load_rd;

  // byte seen at a result address; checksum is the modulo-256 sum
  function automatic logic [7:0] rd_byte(input logic [6:0] p,
                                         input logic [15:0] t,
                                         input logic [15:0] h);
    logic [7:0] b;
    b = 8'h00;
    case (p)
      RES_TEMP: b = t[15:8];
      RES_TEMP + 7'h01: b = t[7:0];
      RES_TEMP + 7'h02: b = t[15:8] + t[7:0];
      RES_HUM: b = h[15:8];
      RES_HUM + 7'h01: b = h[7:0];
      RES_HUM + 7'h02: b = h[15:8] + h[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction : rd_byte

  // pin and toggle synchronisers; a level counts once stages two and three agree
  always_comb begin
    scl_sy_d = {scl_sy_q[1:0], scl_i};
    sda_sy_d = {sda_sy_q[1:0], sda_i};
    tgl_sy_d = {tgl_sy_q[1:0], upd_tgl_w};
    scl_d = (scl_sy_q[1] == scl_sy_q[2]) ? scl_sy_q[2] : scl_q;
    sda_d = (sda_sy_q[1] == sda_sy_q[2]) ? sda_sy_q[2] : sda_q;
    seen_d = seen_q;
    rtemp_d = rtemp_q;
    rhum_d = rhum_q;
    // result words sit still for a whole period, so one sample is safe
    if (tgl_sy_q[1] == tgl_sy_q[2] && tgl_sy_q[2] != seen_q) begin
      seen_d = tgl_sy_q[2];
      rtemp_d = temp_w;
      rhum_d = hum_w;
    end
  end

  // bus events from filtered levels
  assign scl_rise = scl_d & ~scl_q;
  assign scl_fall = ~scl_d & scl_q;
  assign start = scl_q & scl_d & sda_q & ~sda_d;
  assign stop = scl_q & scl_d & ~sda_q & sda_d;
  assign rx_byte = {sh_q[6:0], sda_d};
  assign addr_done = (state_q == ST_ADDR) && scl_rise && (bit_q == 3'h7);
  assign addr_hit = (rx_byte[7:1] == SLAVE_ADDR);
  assign wr_done = (state_q == ST_WR) && scl_rise && (bit_q == 3'h7);

  // protocol engine: bits sampled on rising clock, outputs change on falling
  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    ph_d = ph_q;
    wr_idx_d = wr_idx_q;
    rw_d = rw_q;
    cmd_d = cmd_q;
    sh_d = sh_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    if (stop) begin
      state_d = ST_IDLE;
    end else if (start) begin
      state_d = ST_ADDR;
      bit_d = 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: state_d = ST_IDLE;
        ST_ADDR: if (scl_rise) begin
          sh_d = rx_byte;
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            state_d = addr_hit ? ST_ADDR_ACK : ST_IDLE;
            rw_d = sda_d;
            ph_d = 2'h0;
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: if (scl_fall) begin
          if (ph_q == 2'h0) begin
            ph_d = 2'h1;
          end else begin
            ph_d = 2'h0;
            bit_d = 3'h0;
            if (state_q == ST_ADDR_ACK && rw_q) begin
              state_d = ST_RD;
              tx_d = rd_byte(ptr_q, rtemp_q, rhum_q);
            end else begin
              state_d = ST_WR;
              if (state_q == ST_ADDR_ACK) wr_idx_d = 2'h0;
            end
          end
        end
        ST_WR: if (scl_rise) begin
          sh_d = rx_byte;
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            state_d = ST_WR_ACK;
            ph_d = 2'h0;
            if (wr_idx_q != 2'h3) wr_idx_d = wr_idx_q + 2'h1;
            if (wr_idx_q == 2'h0) cmd_d = (rx_byte == CMD_RD_RESULT);
            if (wr_idx_q == 2'h1 && cmd_q) ptr_d = rx_byte[6:0];
          end
        end
        ST_RD: begin
          if (scl_fall) tx_d = {tx_q[6:0], 1'b0};
          if (scl_rise) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              state_d = ST_RD_ACK;
              ph_d = 2'h0;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_fall && ph_q == 2'h0) ph_d = 2'h1;
          if (scl_rise && ph_q == 2'h1) begin
            if (sda_d) begin
              state_d = ST_IDLE;
            end else begin
              ptr_d = ptr_q + 7'h01;
              ph_d = 2'h2;
            end
          end
          if (scl_fall && ph_q == 2'h2) begin
            state_d = ST_RD;
            bit_d = 3'h0;
            tx_d = rd_byte(ptr_q, rtemp_q, rhum_q);
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  assign load_rd = (state_d == ST_RD) && (state_q != ST_RD);

  // drive only acknowledges and read data bits; hold after the fall first
  always_comb begin
    want = ((state_q == ST_ADDR_ACK || state_q == ST_WR_ACK) && ph_q == 2'h1) ||
           (state_q == ST_RD && !tx_q[7]);
    hold_d = scl_fall ? 8'(HOLD_CYC) : ((hold_q != 8'h00) ? hold_q - 8'h01 : hold_q);
    oe_d = sda_oe_o;
    if (start || stop || state_q == ST_IDLE) begin
      oe_d = 1'b0;
    end else if (hold_q == 8'h01) begin
      oe_d = want;
    end
  end

  // open-drain: only ever pulls low, clock is never driven
  assign sda_o = 1'b0;

  always_ff @(posedge link_clk_i or posedge lrst) begin
    if (lrst) begin
      state_q <= ST_IDLE;
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
      tgl_sy_q <= 3'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      seen_q <= 1'b0;
      rtemp_q <= RESULT_RST;
      rhum_q <= RESULT_RST;
      bit_q <= 3'h0;
      ph_q <= 2'h0;
      wr_idx_q <= 2'h0;
      rw_q <= 1'b0;
      cmd_q <= 1'b0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= PTR_RST;
      hold_q <= 8'h00;
      sda_oe_o <= 1'b0;
    end else begin
      state_q <= state_d;
      scl_sy_q <= scl_sy_d;
      sda_sy_q <= sda_sy_d;
      tgl_sy_q <= tgl_sy_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      seen_q <= seen_d;
      rtemp_q <= rtemp_d;
      rhum_q <= rhum_d;
      bit_q <= bit_d;
      ph_q <= ph_d;
      wr_idx_q <= wr_idx_d;
      rw_q <= rw_d;
      cmd_q <= cmd_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      hold_q <= hold_d;
      sda_oe_o <= oe_d;
    end
  end

  // checks on the link side
  default clocking lcb @(posedge link_clk_i); endclocking
  default disable iff (lrst);

  a_addr_hit_ack: assert property (addr_done && addr_hit |=> state_q == ST_ADDR_ACK)
    else $error("own address not accepted");
  a_addr_miss_quiet: assert property (addr_done && !addr_hit |=> state_q == ST_IDLE && !sda_oe_o)
    else $error("foreign address acknowledged");
  a_ack_driven: assert property ((state_q == ST_ADDR_ACK || state_q == ST_WR_ACK) && ph_q == 2'h1 &&
    hold_q == 8'h01 |=> sda_oe_o)
    else $error("acknowledge not driven low");
  a_write_quiet: assert property (state_q == ST_WR && hold_q == 8'h00 |-> !sda_oe_o)
    else $error("data line driven during write payload");
  a_read_bit_out: assert property (state_q == ST_RD && hold_q == 8'h00 && !scl_fall |-> sda_oe_o == !tx_q[7])
    else $error("read bit not presented");
  a_nack_ends: assert property (state_q == ST_RD_ACK && ph_q == 2'h1 && scl_rise && sda_d |=>
    state_q == ST_IDLE && !sda_oe_o)
    else $error("read not ended by not-acknowledge");
  a_ack_increment: assert property (state_q == ST_RD_ACK && ph_q == 2'h1 && scl_rise && !sda_d |=>
    ptr_q == $past(ptr_q) + 7'h01)
    else $error("address not incremented on acknowledge");
  a_cmd_pointer: assert property (wr_done && wr_idx_q == 2'h1 && cmd_q |=> ptr_q == 7'($past(rx_byte)))
    else $error("result address not taken from opcode payload");
  a_checksum: assert property (load_rd && ptr_q == 7'h02 |=>
    tx_q == 8'($past(rtemp_q) >> 8) + 8'($past(rtemp_q)))
    else $error("checksum byte wrong");
  a_stop_release: assert property (stop |=> state_q == ST_IDLE && !sda_oe_o)
    else $error("bus not released after stop");

  c_addr_miss: cover property (addr_done && !addr_hit);
  c_write_cmd: cover property (wr_done && wr_idx_q == 2'h0 && rx_byte == CMD_RD_RESULT);
  c_read_autoinc: cover property (state_q == ST_RD_ACK && scl_rise && ph_q == 2'h1 && !sda_d);
  c_read_nack: cover property (state_q == ST_RD_ACK && scl_rise && ph_q == 2'h1 && sda_d);

endmodule : hsi_i2c_slave

// File: test/hsi_bus_master.sv
/*
  Behavioural bus master driving the sensor slave: clock plus open-drain data.
  Assumes the bench resolves the data wire with a pull-up and returns it on sda_i.
*/
`timescale 1ns/1ps
module hsi_bus_master #(
  parameter int Q_NS = 2500
) (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // idle: both lines released to the pull-ups
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // one clock pulse, four quarters give 10 us, the fastest legal rate
  task automatic pulse(output logic smp);
    #(Q_NS);
    scl_o = 1'b1;
    #1;
    smp = sda_i;
    #(2 * Q_NS - 1);
    scl_o = 1'b0;
    #(Q_NS);
  endtask : pulse

  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sda_low_o = 1'b0;
    #(Q_NS);
    scl_o = 1'b1;
    #(2 * Q_NS);
    sda_low_o = 1'b1;
    #(2 * Q_NS);
    scl_o = 1'b0;
    #(Q_NS);
  endtask : start_cond

  // stop: data rises while the clock is high, then bus free time
  task automatic stop_cond();
    sda_low_o = 1'b1;
    #(Q_NS);
    scl_o = 1'b1;
    #(2 * Q_NS);
    sda_low_o = 1'b0;
    #(2 * Q_NS);
  endtask : stop_cond

  // msb first; clash flags any data bit sent as 1 that the slave pulled down
  task automatic send_byte(input logic [7:0] b, output logic ack, output logic clash);
    logic s;
    clash = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sda_low_o = ~b[i];
      pulse(s);
      if (s !== b[i]) clash = 1'b1;
    end
    sda_low_o = 1'b0;
    pulse(ack);
  endtask : send_byte

  // read one byte, then acknowledge low or refuse high
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    sda_low_o = 1'b0;
    for (int i = 7; i >= 0; i--) pulse(b[i]);
    // acknowledge level stays until the next call or stop changes it, never twice at once
    sda_low_o = ~nack;
    pulse(s);
  endtask : recv_byte
endmodule : hsi_bus_master

// File: test/tb_top.sv
/*
  Self-checking bench of the sensor slave top: sequencer timing monitor,
  table of result reads, then foreign address, pointer carry-over, reset.
  Assumes shortened sequencer counts and the bus master model beside it.
*/
`timescale 1ns/1ps
`define CHK(got_v, exp_v) begin samples_checked++; if ((got_v) !== (exp_v)) begin n_errors++; \
  $display("Error %0t: got %0h expected %0h", $time, (got_v), (exp_v)); end end
module tb_top import hsi_pkg::*; ;
  localparam int ST = 200;
  localparam int CP = 40;
  localparam int RS = 10;
  localparam int CL = 8;
  localparam int CY = 400;
  localparam int LIMIT = 600000;
  typedef struct {
    logic [15:0] t;
    logic [15:0] h;
    logic [6:0] ra;
    int n;
  } hsi_row_t;
  hsi_row_t rows [2] = '{'{16'h1A80, 16'h3240, RES_TEMP, 6}, '{16'hF6C0, 16'h5A33, RES_HUM, 3}};
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int e, t_cap, t_res, t_calc, n_rise;
  logic mclk_i, rst_i, link_clk, scl_w, sda_w, sda_o, sda_oe, mst_low, oe_seen;
  logic cap, res, calc, c_q, r_q, k_q, a, cl;
  logic [15:0] temp, hum;
  logic [7:0] b;

  hsi_i2c_slave #(.STARTUP_CYC(ST), .CAP_CYC(CP), .RES_CYC(RS), .CALC_CYC(CL), .CYCLE_CYC(CY)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .link_clk_i(link_clk), .scl_i(scl_w), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .temp_i(temp), .hum_i(hum),
    .cap_busy_o(cap), .res_busy_o(res), .calc_busy_o(calc));
  hsi_bus_master mst (.sda_i(sda_w), .scl_o(scl_w), .sda_low_o(mst_low));

  // open-drain wire with pull-up: low if either party pulls it
  assign sda_w = mst_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);

  // system clock and a free link clock of unrelated phase
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  always @(posedge sda_oe) oe_seen = 1'b1;

  // hang guard, roughly one and a half times the expected run
  always @(posedge mclk_i) begin
    cyc++;
    if (rst_i) e = 0;
    else e++;
    if (cyc == LIMIT) begin
      n_errors++;
      report_and_stop();
    end
  end

  // sequencer monitor at the falling edge, where outputs have settled
  always @(negedge mclk_i) begin
    if (rst_i) begin
      n_rise = 0;
    end else begin
      if (cap && !c_q) begin
        if (n_rise == 0) `CHK(e, ST)
        else `CHK(e - t_cap, CY)
        t_cap = e;
        n_rise++;
      end
      if (!cap && c_q) begin
        `CHK(e - t_cap, CP)
        `CHK(res, 1'b1)
        t_res = e;
      end
      if (!res && r_q) begin
        `CHK(e - t_res, RS)
        `CHK(calc, 1'b1)
        t_calc = e;
      end
      if (!calc && k_q) `CHK(e - t_calc, CL)
    end
    c_q = cap;
    r_q = res;
    k_q = calc;
  end

  // pointer 0..5: temperature then humidity, high, low, sum; else zero
  function automatic logic [7:0] exp_byte(input int p, input logic [15:0] t, input logic [15:0] h);
    logic [15:0] v;
    if (p > 5) return 8'h00;
    v = (p < 3) ? t : h;
    if (p % 3 == 0) return v[15:8];
    if (p % 3 == 1) return v[7:0];
    return v[15:8] + v[7:0];
  endfunction : exp_byte

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : step

  // read command and result address, then turn round with a repeated start
  task automatic point_read(input logic [6:0] ra);
    mst.start_cond();
    mst.send_byte({SLAVE_ADDR, 1'b0}, a, cl);
    `CHK(a, 1'b0)
    mst.send_byte(CMD_RD_RESULT, a, cl);
    `CHK(cl, 1'b0)
    mst.send_byte({1'b0, ra}, a, cl);
    `CHK(a, 1'b0)
    mst.start_cond();
    mst.send_byte({SLAVE_ADDR, 1'b1}, a, cl);
    `CHK(a, 1'b0)
  endtask : point_read

  // n bytes from pointer p0, last one refused, then stop
  task automatic read_n(input int p0, input int n, input logic [15:0] t, input logic [15:0] h);
    for (int k = 0; k < n; k++) begin
      mst.recv_byte(k == n - 1, b);
      `CHK(b, exp_byte(p0 + k, t, h))
    end
    mst.stop_cond();
    `CHK(sda_w, 1'b1)
  endtask : read_n

  task automatic report_and_stop();
    $display("checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // main sequence: table rows, then the awkward cases
  initial begin
    rst_i = 1'b1;
    temp = 16'h0000;
    hum = 16'h0000;
    oe_seen = 1'b0;
    repeat (6) @(posedge mclk_i);
    repeat (3) @(posedge link_clk);
    step(1);
    rst_i = 1'b0;
    step(50);
    foreach (rows[i]) begin
      temp = rows[i].t;
      hum = rows[i].h;
      step(1000);
      point_read(rows[i].ra);
      read_n(int'(rows[i].ra), rows[i].n, rows[i].t, rows[i].h);
    end
    // foreign address: no acknowledge, line never pulled
    oe_seen = 1'b0;
    mst.start_cond();
    mst.send_byte({SLAVE_ADDR + 7'h01, 1'b0}, a, cl);
    `CHK(a, 1'b1)
    mst.stop_cond();
    `CHK(oe_seen, 1'b0)
    // plain read resumes at the pointer the last refusal left, past the end
    mst.start_cond();
    mst.send_byte({SLAVE_ADDR, 1'b1}, a, cl);
    `CHK(a, 1'b0)
    read_n(5, 2, rows[1].t, rows[1].h);
    // second reset mid-run: bus released, sequencer idle, then restarts
    step(1);
    rst_i = 1'b1;
    step(6);
    `CHK({sda_oe, cap, res, calc}, 4'h0)
    repeat (3) @(posedge link_clk);
    step(1);
    rst_i = 1'b0;
    step(1000);
    report_and_stop();
  end
endmodule : tb_top
